/* src/rsc_pkg.sv */
// Constants shared by the reset source control block
`default_nettype none
package rsc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CAUSE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] PIN_STAT_OFS = 8'h10;
  // ==========================================================================
  // Cause flag layout, shared by cause, interrupt status and mask registers
  localparam int CAUSE_W = 6;
  localparam int POWER_ON_FLAG_BIT = 0;
  localparam int BROWNOUT_FLAG_BIT = 1;
  localparam int WATCHDOG_FLAG_BIT = 2;
  localparam int SOFTWARE_FLAG_BIT = 3;
  localparam int BREAK_FLAG_BIT = 4;
  localparam int PIN_FLAG_BIT = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h03;
  localparam logic [CAUSE_W-1:0] CAUSE_ALL_ONES = 6'h3f;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 6'h00;
  // ==========================================================================
  // Config register fields
  localparam int CFG_PIN_ENABLE_BIT = 0;
  localparam int CFG_SW_RESET_BIT = 1;
  localparam logic CFG_PIN_ENABLE_RESET = 1'b1;
  // ==========================================================================
  // Pin status register fields
  localparam int PIN_LEVEL_BIT = 0;
  localparam int PIN_MODE_BIT = 1;
  localparam int PIN_PULLUP_BIT = 2;
  localparam int PIN_POWERUP_BIT = 3;
  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rsc_pkg
`default_nettype wire

/* src/rsc_reset_source_control.sv */
// Reset source combiner, shared pin control and reset cause record
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module rsc_reset_source_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_detect,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic break_detect,
  input wire logic shared_reset_input_pin,
  output logic pin_pullup_en,
  output logic gpio_in_level,
  output logic chip_reset_n,
  output logic irq
);

  // ==========================================================================
  // Declarations
  localparam int NRAW = 4;
  localparam int R_POR = 0;
  localparam int R_BOD = 1;
  localparam int R_WDT = 2;
  localparam int R_BRK = 3;

  logic [NRAW-1:0] raw_vec;
  logic [NRAW-1:0] raw_s1_reg;
  logic [NRAW-1:0] raw_s2_reg;
  logic [NRAW-1:0] raw_prev_reg;
  logic [NRAW-1:0] raw_rise;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_prev_reg;
  logic pin_active;
  logic gpio_reg;
  logic powerup_reg;
  logic powerup_next;
  logic pin_enable_reg;
  logic pin_mode_reset;
  logic sw_req_reg;
  logic raw_reset;
  logic [1:0] rst_sync_reg;
  logic [rsc_pkg::CAUSE_W-1:0] events;
  logic full_reset_event;
  logic [rsc_pkg::CAUSE_W-1:0] cause_reg;
  logic [rsc_pkg::CAUSE_W-1:0] cause_next;
  logic [rsc_pkg::CAUSE_W-1:0] cause_keep;
  logic [rsc_pkg::CAUSE_W-1:0] irq_stat_reg;
  logic [rsc_pkg::CAUSE_W-1:0] irq_stat_next;
  logic [rsc_pkg::CAUSE_W-1:0] irq_w1c;
  logic [rsc_pkg::CAUSE_W-1:0] irq_mask_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [rsc_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wlane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write;
  logic wr_en;
  logic wr_cause;
  logic wr_config;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_mapped;
  logic rd_take;
  logic rd_mapped;
  logic [31:0] rd_value;
  logic [31:0] pin_status;

  // ==========================================================================
  // Input synchronisers for asynchronous cause lines and the pin
  assign raw_vec = {break_detect, watchdog_timeout, brownout_detect, power_on_detect};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_s1_reg <= '0;
      raw_s2_reg <= '0;
      raw_prev_reg <= '0;
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_prev_reg <= 1'b0;
      gpio_reg <= 1'b1;
    end
    else
    begin
      raw_s1_reg <= raw_vec;
      raw_s2_reg <= raw_s1_reg;
      raw_prev_reg <= raw_s2_reg;
      pin_s1_reg <= shared_reset_input_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_active;
      gpio_reg <= pin_mode_reset ? 1'b1 : pin_s2_reg; // Input data only in input mode
    end
  end

  // Rising edges of synchronised causes
  assign raw_rise = raw_s2_reg & ~raw_prev_reg;

  // ==========================================================================
  // Pin function selection
  // Power-up phase holds from power-on until the chip leaves reset with power good
  assign powerup_next = raw_s2_reg[R_POR] ? 1'b1 :
                        (chip_reset_n ? 1'b0 : powerup_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      powerup_reg <= 1'b1;
    end
    else
    begin
      powerup_reg <= powerup_next;
    end
  end

  // Enable bit selects mode, power-up overrides it; no other cause does
  assign pin_mode_reset = pin_enable_reg | powerup_reg;
  assign pin_pullup_en = pin_mode_reset;
  assign pin_active = ~pin_s2_reg & pin_mode_reset;
  assign gpio_in_level = gpio_reg;

  // ==========================================================================
  // Chip reset combiner
  // A low pin in reset mode keeps the chip in reset, which the far side must avoid at power-on
  assign raw_reset = power_on_detect | brownout_detect | watchdog_timeout | break_detect |
                     sw_req_reg | (~shared_reset_input_pin & pin_mode_reset);

  // Asserts at once, releases on the second clock edge after all causes drop
  always_ff @(posedge aclk or posedge raw_reset)
  begin
    if (raw_reset)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign chip_reset_n = rst_sync_reg[1];

  // ==========================================================================
  // Cause events and flag update
  assign events[rsc_pkg::POWER_ON_FLAG_BIT] = raw_rise[R_POR];
  assign events[rsc_pkg::BROWNOUT_FLAG_BIT] = raw_rise[R_BOD];
  assign events[rsc_pkg::WATCHDOG_FLAG_BIT] = raw_rise[R_WDT];
  assign events[rsc_pkg::SOFTWARE_FLAG_BIT] = sw_req_reg;
  assign events[rsc_pkg::BREAK_FLAG_BIT] = raw_rise[R_BRK];
  assign events[rsc_pkg::PIN_FLAG_BIT] = pin_active & ~pin_prev_reg;

  assign full_reset_event = events[rsc_pkg::POWER_ON_FLAG_BIT] | events[rsc_pkg::WATCHDOG_FLAG_BIT];

  // Written zeros clear, written ones keep; a new event wins over the clear
  assign cause_keep = wr_cause ? wdata_reg[rsc_pkg::CAUSE_W-1:0] : rsc_pkg::CAUSE_ALL_ONES;
  assign cause_next = full_reset_event ? rsc_pkg::CAUSE_RESET :
                      ((cause_reg & cause_keep) | events);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cause_reg <= rsc_pkg::CAUSE_RESET;
    end
    else
    begin
      cause_reg <= cause_next;
    end
  end

  // ==========================================================================
  // Interrupt status, mask and output
  assign irq_w1c = wr_irq_stat ? wdata_reg[rsc_pkg::CAUSE_W-1:0] : rsc_pkg::CAUSE_NONE;
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | events;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= rsc_pkg::CAUSE_NONE;
      irq_mask_reg <= rsc_pkg::CAUSE_NONE;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_irq_mask)
      begin
        irq_mask_reg <= wdata_reg[rsc_pkg::CAUSE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Config register and software reset strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_enable_reg <= rsc_pkg::CFG_PIN_ENABLE_RESET;
      sw_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_config)
      begin
        pin_enable_reg <= wdata_reg[rsc_pkg::CFG_PIN_ENABLE_BIT];
      end
      sw_req_reg <= wr_config & wdata_reg[rsc_pkg::CFG_SW_RESET_BIT];
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_en = do_write & wlane0_reg;
  assign wr_cause = wr_en & (awaddr_reg == rsc_pkg::CAUSE_OFS);
  assign wr_config = wr_en & (awaddr_reg == rsc_pkg::CONFIG_OFS);
  assign wr_irq_stat = wr_en & (awaddr_reg == rsc_pkg::IRQ_STAT_OFS);
  assign wr_irq_mask = wr_en & (awaddr_reg == rsc_pkg::IRQ_MASK_OFS);
  assign wr_mapped = (awaddr_reg == rsc_pkg::CAUSE_OFS) | (awaddr_reg == rsc_pkg::CONFIG_OFS) |
                     (awaddr_reg == rsc_pkg::IRQ_STAT_OFS) | (awaddr_reg == rsc_pkg::IRQ_MASK_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wlane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= rsc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wlane0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ==========================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = ~rvalid_reg;
  assign rd_take = s_axi_arvalid & ~rvalid_reg;
  assign pin_status = {28'h0000000, powerup_reg, pin_pullup_en, pin_mode_reset, pin_s2_reg};
  assign rd_mapped = (s_axi_araddr == rsc_pkg::CAUSE_OFS) | (s_axi_araddr == rsc_pkg::CONFIG_OFS) |
                     (s_axi_araddr == rsc_pkg::IRQ_STAT_OFS) | (s_axi_araddr == rsc_pkg::IRQ_MASK_OFS) |
                     (s_axi_araddr == rsc_pkg::PIN_STAT_OFS);
  assign rd_value = (s_axi_araddr == rsc_pkg::CAUSE_OFS) ? {26'h0, cause_reg} :
                    (s_axi_araddr == rsc_pkg::CONFIG_OFS) ? {31'h0, pin_enable_reg} :
                    (s_axi_araddr == rsc_pkg::IRQ_STAT_OFS) ? {26'h0, irq_stat_reg} :
                    (s_axi_araddr == rsc_pkg::IRQ_MASK_OFS) ? {26'h0, irq_mask_reg} :
                    (s_axi_araddr == rsc_pkg::PIN_STAT_OFS) ? pin_status : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= rsc_pkg::RESP_OKAY;
      rdata_reg <= '0;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_mapped ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      rdata_reg <= rd_value;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule : rsc_reset_source_control
`default_nettype wire

/* tb/rsc_checker.sv */
// Assertion checker for the reset source control block
`default_nettype none
module rsc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic power_on_detect,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic break_detect,
  input wire logic shared_reset_input_pin,
  input wire logic pin_pullup_en,
  input wire logic gpio_in_level,
  input wire logic chip_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Shared timing and raw causes
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic hard = power_on_detect | brownout_detect | watchdog_timeout | break_detect;
  wire logic pin_low = pin_pullup_en & !shared_reset_input_pin;
  // ======
  // Chip reset generation
  a_cause_reset: assert property (hard |-> !chip_reset_n)
    else $error("chip reset not low with a cause active");
  a_pin_reset: assert property (pin_low |-> !chip_reset_n)
    else $error("low reset pin did not reset the chip");
  a_release_sync: assert property ($rose(chip_reset_n) |-> !$past(hard)
    && !$past(hard, 2) && !$past(pin_low))
    else $error("chip reset released too early");
  a_pin_ignored: assert property ($fell(shared_reset_input_pin) && !pin_pullup_en && !hard
    && chip_reset_n |=> chip_reset_n)
    else $error("input pin caused a reset");
  // ======
  // Pin mode and pull-up
  a_gpio_follow: assert property (!pin_pullup_en && !$past(pin_pullup_en, 3)
    |-> gpio_in_level == $past(shared_reset_input_pin, 3))
    else $error("input level does not follow pin");
  a_pullup_high: assert property (pin_pullup_en |-> gpio_in_level)
    else $error("input level not forced in reset mode");
  a_powerup_pull: assert property ($rose(power_on_detect) |-> ##[1:4] pin_pullup_en)
    else $error("power-up did not force reset mode");
  a_mode_kept: assert property (!pin_pullup_en && !power_on_detect && !$past(power_on_detect)
    && !s_axi_awvalid && !$past(s_axi_awvalid) |=> !pin_pullup_en)
    else $error("pin mode changed without cause");
  // ======
  // Main scenarios reached
  c_hard: cover property (hard ##1 !hard);
  c_pin: cover property (pin_low);
  c_mode: cover property ($fell(pin_pullup_en));
endmodule : rsc_checker
`default_nettype wire

/* tb/rsc_reset_supervisor.sv */
// Outside reset supervisor model driving the shared pin
`default_nettype none
module rsc_reset_supervisor (
  input wire logic power_on_detect,
  input wire logic press,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Released line rests high on the pull-up; never low in power-on
  always_comb
  begin
    pin = !(press && !power_on_detect);
  end
endmodule : rsc_reset_supervisor
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the reset source control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CAU = rsc_pkg::CAUSE_OFS;
  localparam logic [7:0] CFG = rsc_pkg::CONFIG_OFS;
  localparam logic [7:0] IST = rsc_pkg::IRQ_STAT_OFS;
  localparam logic [7:0] IMK = rsc_pkg::IRQ_MASK_OFS;
  localparam logic [7:0] PST = rsc_pkg::PIN_STAT_OFS;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic [4:0] ev = 5'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pin, pin_pullup_en, gpio_in_level, chip_reset_n, irq;
  logic lvl;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // ======
  // Design and pin partner
  rsc_reset_source_control rsc_reset_source_control_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .power_on_detect(ev[0]), .brownout_detect(ev[1]), .watchdog_timeout(ev[2]),
    .break_detect(ev[3]), .shared_reset_input_pin(pin), .pin_pullup_en, .gpio_in_level, .chip_reset_n, .irq
  );
  rsc_reset_supervisor rsc_reset_supervisor_inst (.power_on_detect(ev[0]), .press(ev[4]), .pin);
  // Clock and hang ceiling
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ======
  // Verdict, compare and bus tasks
  task automatic summarize();
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp = rsc_pkg::RESP_OKAY);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, rsp});
  endtask : wr
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp = rsc_pkg::RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, rsp});
  endtask : rdx
  // Raise one cause for 4 cycles; chip reset must release 2 edges after
  task automatic pulse(input int k, input logic rst, output logic pu);
    ev[k] <= 1'b1;
    repeat (4) @(posedge aclk);
    pu = pin_pullup_en;
    lvl = gpio_in_level;
    ev[k] <= 1'b0;
    @(negedge aclk);
    chk({31'h0, chip_reset_n}, {31'h0, !rst});
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, chip_reset_n}, 32'h1);
    repeat (4) @(posedge aclk);
  endtask : pulse
  // ======
  // Main sequence
  initial
  begin
    logic pu;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rdx(CAU, 32'h03);
    rdx(CFG, 32'h01);
    rdx(PST, 32'h07);
    rdx(IMK, 32'h00);
    rdx(8'h14, 32'h0, rsc_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0, rsc_pkg::RESP_SLVERR);
    wr(CAU, 32'h3e);
    rdx(CAU, 32'h02);
    wr(CAU, 32'h00);
    wr(IMK, 32'h04);
    pulse(1, 1'b1, pu);
    rdx(CAU, 32'h02);
    pulse(3, 1'b1, pu);
    rdx(CAU, 32'h12);
    wr(CFG, 32'h03);
    repeat (6) @(posedge aclk);
    rdx(CAU, 32'h1a);
    rdx(CFG, 32'h01);
    pulse(4, 1'b1, pu);
    chk({31'h0, lvl}, 32'h1);
    rdx(CAU, 32'h3a);
    chk({31'h0, irq}, 32'h0);
    pulse(2, 1'b1, pu);
    rdx(CAU, 32'h03);
    chk({31'h0, irq}, 32'h1);
    wr(IST, 32'h3f);
    rdx(IST, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(CFG, 32'h00);
    rdx(PST, 32'h01);
    pulse(4, 1'b0, pu);
    chk({31'h0, lvl}, 32'h0);
    rdx(CAU, 32'h03);
    pulse(2, 1'b1, pu);
    chk({31'h0, pu}, 32'h0);
    rdx(CFG, 32'h00);
    pulse(0, 1'b1, pu);
    chk({31'h0, pu}, 32'h1);
    rdx(CAU, 32'h03);
    chk({31'h0, pin_pullup_en}, 32'h0);
    // Second block reset in mid-run restores the reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdx(CAU, 32'h03);
    rdx(CFG, 32'h01);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, pin_pullup_en}, 32'h1);
    summarize();
  end
endmodule : tb
bind rsc_reset_source_control rsc_checker rsc_checker_inst (
  .aclk, .aresetn, .s_axi_awvalid, .power_on_detect, .brownout_detect, .watchdog_timeout,
  .break_detect, .shared_reset_input_pin, .pin_pullup_en, .gpio_in_level, .chip_reset_n
);
`default_nettype wire
